// ### rtl/emt_pkg.sv
// package: register map, field layout, timing counts and carrier types
package emt_pkg;

   // ----------------------------------------------------------------
   // register indices (byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam int unsigned IDX_W = 10;
   localparam logic [9:0] IDX_TIMING = 10'h0aa;
   localparam logic [9:0] IDX_CFG = 10'h0ab;
   localparam logic [9:0] IDX_PAGE = 10'h0ac;
   localparam logic [9:0] IDX_PTR = 10'h0ad;
   localparam logic [9:0] IDX_WDATA = 10'h0ae;
   localparam logic [9:0] IDX_CMD = 10'h0af;
   localparam logic [9:0] IDX_RDATA = 10'h0b0;

   // ----------------------------------------------------------------
   // reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_TIMING = 8'hff;
   localparam logic [2:0] RST_CFG = 3'h0;
   localparam int unsigned EAS_LSB = 6;
   localparam int unsigned EWR_LSB = 2;
   localparam int unsigned EAH_LSB = 0;
   localparam int unsigned CFG_LSB = 2;
   localparam int unsigned CMD_START = 0;
   localparam int unsigned CMD_WRITE = 1;
   localparam int unsigned CMD_WIDE = 2;
   localparam int unsigned ST_BUSY = 0;
   localparam int unsigned ST_DONE = 1;
   // low two bits of the configuration code
   localparam logic [1:0] MODE_INTERNAL = 2'h0;
   localparam logic [1:0] MODE_BANK = 2'h2;

   // ----------------------------------------------------------------
   // fixed phase lengths in core-clock cycles
   // ----------------------------------------------------------------
   localparam logic [4:0] LEAD_CYC = 5'h02;
   localparam logic [4:0] TRAIL_CYC = 5'h02;
   localparam logic [4:0] ALE_HI_CYC = 5'h01;
   localparam logic [4:0] ALE_LO_CYC = 5'h01;
   localparam logic [5:0] MUX_EXTRA = 6'h02;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      PH_IDLE, PH_ALE_HI, PH_ALE_LO, PH_LEAD,
      PH_SETUP, PH_STROBE, PH_HOLD, PH_TRAIL
   } emt_phase_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [11:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } emt_wb_req_t;

   typedef struct packed {
      logic [7:0] addr_hi;
      logic addr_hi_oe_n;
      logic [7:0] addr_lo;
      logic addr_lo_oe_n;
      logic [7:0] ad;
      logic ad_oe_n;
      logic ale;
      logic rd_n;
      logic wr_n;
   } emt_pins_t;

   localparam emt_pins_t PINS_IDLE = '{addr_hi_oe_n: 1'b1,
      addr_lo_oe_n: 1'b1, ad_oe_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
      default: '0};

   typedef struct packed {
      logic [7:0] tmg;
      logic [2:0] cfg;
      logic [7:0] page;
      logic [15:0] ptr;
      logic [7:0] wdat;
      logic [7:0] rdat;
      logic ack;
      logic [31:0] dat;
      logic [7:0] ad_s1;
      logic [7:0] ad_s2;
      emt_phase_t ph;
      logic busy;
      logic done;
      logic [7:0] s_tmg;
      logic s_wr;
      logic s_wide;
      logic s_mux;
      logic s_bank;
      logic [7:0] s_ahi;
      logic [7:0] s_alo;
      logic [7:0] s_dat;
      emt_pins_t pins;
   } emt_state_t;

   localparam emt_state_t ST_RESET = '{tmg: RST_TIMING, cfg: RST_CFG,
      ph: PH_IDLE, pins: PINS_IDLE, default: '0};

   typedef struct packed {
      logic [3:0] cnt;
   } emt_cnt_t;

endpackage

// ### rtl/emt_phase_cnt.sv
// down-counter that times one sequencer phase
module emt_phase_cnt #(
   parameter int unsigned W = 4
) (
   input wire logic clk_i, // core clock
   input wire logic rst_i, // sync reset, high
   input wire logic ce_i, // clock enable
   input wire logic load_i, // load count
   input wire logic [3:0] val_i, // cycles minus one
   output logic zero_o // count at zero
);
   import emt_pkg::*;

   emt_cnt_t r;
   emt_cnt_t nx;

   always_comb begin
      nx = r;
      if (load_i) begin
         nx.cnt = val_i;
      end else if (r.cnt != 4'h0) begin
         nx.cnt = r.cnt - 4'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
      end else if (ce_i) begin
         r <= nx;
      end
   end

   assign zero_o = (r.cnt == 4'h0);
endmodule // emt_phase_cnt

// ### rtl/emt_ctrl.sv
// external memory interface: registers, timing sequencer and pins
//
// Contract
// - setup field bits 7:6 inserts 0 to 3 setup cycles.
// - strobe field bits 5:2 gives strobe width of code plus one cycles.
// - hold field bits 1:0 keeps address 0 to 3 cycles after strobe.
// - timing register at index 0xaa, page 0x0f, fully read/write.
// - codes 101, 110, 111 make 16-bit moves non-multiplexed.
// - codes 101, 111: 8-bit moves non-multiplexed, upper byte undriven.
// - code 110: 8-bit moves non-multiplexed, upper byte from page.
// - codes 001, 010, 011 make 16-bit moves multiplexed with latch strobe.
// - codes 001, 011: 8-bit moves multiplexed, upper byte undriven.
// - code 010: 8-bit moves multiplexed, upper byte from page.
// - after reset the timing register reads all ones.
// - a move lasts programmed timing sum plus four cycles, six when multiplexed.
// - latch strobe high for the first of the two cycles the low address is on shared lines.
// - no-bank 8-bit moves drive only the low byte from index.
module emt_ctrl (
   input wire logic clk_i, // core clock
   input wire logic rst_i, // sync reset, high
   input wire logic ce_i, // clock enable
   input wire emt_pkg::emt_wb_req_t wb_i, // wishbone request
   output logic wb_ack_o, // wishbone ack
   output logic [31:0] wb_dat_o, // wishbone read data
   output logic busy_o, // move in progress
   input wire logic [7:0] ad_i, // shared data pins in
   output emt_pkg::emt_pins_t mem_o // memory pins out
);
   import emt_pkg::*;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [4:0] ph_len(emt_phase_t p, logic [7:0] t);
      logic [4:0] l;
      l = 5'h00;
      unique case (p)
         PH_IDLE: l = 5'h00;
         PH_ALE_HI: l = ALE_HI_CYC;
         PH_ALE_LO: l = ALE_LO_CYC;
         PH_LEAD: l = LEAD_CYC;
         PH_SETUP: l = {3'h0, t[EAS_LSB+:2]};
         PH_STROBE: l = {1'b0, t[EWR_LSB+:4]} + 5'h01;
         PH_HOLD: l = {3'h0, t[EAH_LSB+:2]};
         PH_TRAIL: l = TRAIL_CYC;
      endcase
      return l;
   endfunction

   function automatic emt_phase_t ph_step(emt_phase_t p, logic mux);
      emt_phase_t q;
      q = PH_IDLE;
      unique case (p)
         PH_IDLE: q = mux ? PH_ALE_HI : PH_LEAD;
         PH_ALE_HI: q = PH_ALE_LO;
         PH_ALE_LO: q = PH_LEAD;
         PH_LEAD: q = PH_SETUP;
         PH_SETUP: q = PH_STROBE;
         PH_STROBE: q = PH_HOLD;
         PH_HOLD: q = PH_TRAIL;
         PH_TRAIL: q = PH_IDLE;
      endcase
      return q;
   endfunction

   // next phase, skipping setup or hold when programmed to zero
   function automatic emt_phase_t ph_next(emt_phase_t p, logic mux,
                                         logic [7:0] t);
      emt_phase_t q;
      q = ph_step(p, mux);
      if (q != PH_IDLE && ph_len(q, t) == 5'h00) begin
         q = ph_step(q, mux);
      end
      return q;
   endfunction

   function automatic emt_pins_t pins_for(emt_phase_t p, emt_state_t s);
      emt_pins_t o;
      logic addr_on;
      o = PINS_IDLE;
      o.addr_hi = s.s_ahi;
      o.addr_lo = s.s_alo;
      o.ad = s.s_dat;
      addr_on = (p != PH_IDLE) && (p != PH_TRAIL);
      if (addr_on) begin
         o.addr_hi_oe_n = !(s.s_wide || s.s_bank);
         o.addr_lo_oe_n = s.s_mux;
      end
      if (p == PH_ALE_HI || p == PH_ALE_LO) begin
         o.ad = s.s_alo;
         o.ad_oe_n = 1'b0;
         o.ale = (p == PH_ALE_HI);
      end
      if (s.s_wr && (p == PH_SETUP || p == PH_STROBE || p == PH_HOLD)) begin
         o.ad_oe_n = 1'b0;
      end
      o.rd_n = !(p == PH_STROBE && !s.s_wr);
      o.wr_n = !(p == PH_STROBE && s.s_wr);
      return o;
   endfunction

   function automatic logic [31:0] rd_word(logic [9:0] idx, emt_state_t s);
      logic [31:0] d;
      d = 32'h0;
      unique case (idx)
         IDX_TIMING: d = {24'h0, s.tmg};
         IDX_CFG: d = {27'h0, s.cfg, 2'h0};
         IDX_PAGE: d = {24'h0, s.page};
         IDX_PTR: d = {16'h0, s.ptr};
         IDX_WDATA: d = {24'h0, s.wdat};
         IDX_CMD: d = {30'h0, s.done, s.busy};
         IDX_RDATA: d = {24'h0, s.rdat};
         default: d = 32'h0;
      endcase
      return d;
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   emt_state_t r;
   emt_state_t nx;
   logic cnt_load;
   logic [3:0] cnt_val;
   logic cnt_zero;
   logic [9:0] idx;
   logic req;
   logic start;
   logic [4:0] len;

   assign idx = wb_i.adr[11:2];
   assign req = wb_i.cyc && wb_i.stb && !r.ack;

   emt_phase_cnt #(
      .W(4)
   ) u_cnt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .load_i(cnt_load),
      .val_i(cnt_val),
      .zero_o(cnt_zero)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nx = r;
      cnt_load = 1'b0;
      cnt_val = 4'h0;
      start = 1'b0;
      len = 5'h00;
      nx.ad_s1 = ad_i;
      nx.ad_s2 = r.ad_s1;
      nx.ack = 1'b0;
      if (req) begin
         nx.ack = 1'b1;
         nx.dat = rd_word(idx, r);
         if (wb_i.we) begin
            if (wb_i.sel[0]) begin
               unique case (idx)
                  IDX_TIMING: nx.tmg = wb_i.dat[7:0];
                  IDX_CFG: nx.cfg = wb_i.dat[CFG_LSB+:3];
                  IDX_PAGE: nx.page = wb_i.dat[7:0];
                  IDX_PTR: nx.ptr[7:0] = wb_i.dat[7:0];
                  IDX_WDATA: nx.wdat = wb_i.dat[7:0];
                  IDX_CMD: start = wb_i.dat[CMD_START];
                  default: ;
               endcase
            end
            if (wb_i.sel[1] && idx == IDX_PTR) begin
               nx.ptr[15:8] = wb_i.dat[15:8];
            end
         end
      end
      // internal-only code or a busy sequencer refuses the start
      if (r.ph != PH_IDLE || r.cfg[1:0] == MODE_INTERNAL) begin
         start = 1'b0;
      end
      if (start) begin
         nx.done = 1'b0;
         nx.s_tmg = r.tmg;
         nx.s_wr = wb_i.dat[CMD_WRITE];
         nx.s_wide = wb_i.dat[CMD_WIDE];
         nx.s_mux = !r.cfg[2];
         nx.s_bank = (r.cfg[1:0] == MODE_BANK);
         nx.s_ahi = wb_i.dat[CMD_WIDE] ? r.ptr[15:8] : r.page;
         nx.s_alo = r.ptr[7:0];
         nx.s_dat = r.wdat;
         nx.ph = ph_next(PH_IDLE, nx.s_mux, nx.s_tmg);
      end else if (r.ph != PH_IDLE && cnt_zero) begin
         nx.ph = ph_next(r.ph, r.s_mux, r.s_tmg);
         if (nx.ph == PH_IDLE) begin
            nx.done = 1'b1;
         end
      end
      if (r.ph == PH_STROBE && cnt_zero && !r.s_wr) begin
         nx.rdat = r.ad_s2;
      end
      if (nx.ph != r.ph && nx.ph != PH_IDLE) begin
         len = ph_len(nx.ph, nx.s_tmg);
         cnt_load = 1'b1;
         cnt_val = len[3:0] - 4'h1;
      end
      nx.busy = (nx.ph != PH_IDLE);
      nx.pins = pins_for(nx.ph, nx);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= ST_RESET;
      end else if (ce_i) begin
         r <= nx;
      end
   end

   assign wb_ack_o = r.ack;
   assign wb_dat_o = r.dat;
   assign busy_o = r.busy;
   assign mem_o = r.pins;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [4:0] age_r;
   logic [5:0] tl_r;
   logic [5:0] tl_exp;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         age_r <= 5'h00;
         tl_r <= 6'h00;
      end else if (ce_i) begin
         age_r <= (nx.ph != r.ph) ? 5'h01 : age_r + 5'h01;
         tl_r <= (r.ph == PH_IDLE) ? 6'h01 : tl_r + 6'h01;
      end
   end

   assign tl_exp = {4'h0, r.s_tmg[EAS_LSB+:2]}
      + {2'h0, r.s_tmg[EWR_LSB+:4]} + 6'h01
      + {4'h0, r.s_tmg[EAH_LSB+:2]} + 6'h04
      + (r.s_mux ? MUX_EXTRA : 6'h00);

   property p_setup_len;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && r.ph == PH_SETUP && nx.ph != PH_SETUP)
         |-> age_r == {3'h0, r.s_tmg[EAS_LSB+:2]};
   endproperty
   a_setup_len: assert property (p_setup_len)
      else $error("setup phase length wrong");

   property p_strobe_len;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && r.ph == PH_STROBE && nx.ph != PH_STROBE)
         |-> age_r == {1'b0, r.s_tmg[EWR_LSB+:4]} + 5'h01
            && (mem_o.rd_n ^ mem_o.wr_n);
   endproperty
   a_strobe_len: assert property (p_strobe_len)
      else $error("strobe width wrong");

   property p_hold_len;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && r.ph == PH_HOLD && nx.ph != PH_HOLD)
         |-> age_r == {3'h0, r.s_tmg[EAH_LSB+:2]}
            && mem_o.rd_n && mem_o.wr_n;
   endproperty
   a_hold_len: assert property (p_hold_len)
      else $error("hold phase length wrong");

   property p_tmg_read;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && req && !wb_i.we && idx == IDX_TIMING)
         |=> wb_ack_o && wb_dat_o == {24'h0, $past(r.tmg)};
   endproperty
   a_tmg_read: assert property (p_tmg_read)
      else $error("timing register read mismatch");

   property p_nonmux;
      @(posedge clk_i) disable iff (rst_i)
      (r.ph == PH_STROBE && !r.s_mux)
         |-> !mem_o.addr_lo_oe_n && mem_o.addr_lo == r.s_alo
            && !mem_o.ale;
   endproperty
   a_nonmux: assert property (p_nonmux)
      else $error("non-multiplexed address not driven");

   property p_nobank_hi;
      @(posedge clk_i) disable iff (rst_i)
      (r.ph != PH_IDLE && !r.s_wide && !r.s_bank)
         |-> mem_o.addr_hi_oe_n;
   endproperty
   a_nobank_hi: assert property (p_nobank_hi)
      else $error("upper address driven without bank select");

   property p_bank_hi;
      @(posedge clk_i) disable iff (rst_i)
      (r.ph == PH_STROBE && !r.s_wide && r.s_bank)
         |-> !mem_o.addr_hi_oe_n && mem_o.addr_hi == r.s_ahi;
   endproperty
   a_bank_hi: assert property (p_bank_hi)
      else $error("bank page not driven on upper address");

   property p_mux_lo;
      @(posedge clk_i) disable iff (rst_i)
      (r.ph == PH_STROBE && r.s_mux) |-> mem_o.addr_lo_oe_n;
   endproperty
   a_mux_lo: assert property (p_mux_lo)
      else $error("low address pins driven in multiplexed form");

   property p_reset_ones;
      @(posedge clk_i) rst_i |=> r.tmg == RST_TIMING && !busy_o;
   endproperty
   a_reset_ones: assert property (p_reset_ones)
      else $error("timing register not all ones after reset");

   property p_txn_len;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && r.ph == PH_TRAIL && nx.ph == PH_IDLE) |-> tl_r == tl_exp;
   endproperty
   a_txn_len: assert property (p_txn_len)
      else $error("move length wrong");

   property p_ale;
      @(posedge clk_i) disable iff (rst_i)
      mem_o.ale |-> !mem_o.ad_oe_n && mem_o.ad == r.s_alo
         ##1 (!ce_i || (!mem_o.ale && mem_o.ad == r.s_alo));
   endproperty
   a_ale: assert property (p_ale)
      else $error("latch strobe without low address");

   property p_snap;
      @(posedge clk_i) disable iff (rst_i)
      (r.ph != PH_IDLE && nx.ph != PH_IDLE) |=> $stable(r.s_tmg);
   endproperty
   a_snap: assert property (p_snap)
      else $error("timing changed during a move");

   property p_order;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && nx.ph == PH_STROBE && r.ph != PH_STROBE)
         |-> r.ph == PH_SETUP || r.ph == PH_LEAD;
   endproperty
   a_order: assert property (p_order)
      else $error("strobe entered out of order");
endmodule // emt_ctrl

// ### sim/emt_sram_model.sv
// partner model: byte-wide static ram with a clocked low-address latch, loaded on clock edges while ale is high
module emt_sram_model (
   input wire logic clk_i, // core clock
   input wire emt_pkg::emt_pins_t mem_i, // pins from controller
   input wire logic [7:0] port_hi_i, // port latch upper address
   output logic [7:0] ad_o // data lines back to controller
);
   timeunit 1ns;
   timeprecision 1ns;
   import emt_pkg::*;

   logic [7:0] mem [0:65535];
   logic [7:0] lat;
   logic [7:0] last = 8'h00;
   logic [15:0] addr;

   // ----------------------------------------------------------------
   // address decode and storage
   // ----------------------------------------------------------------
   // upper byte from port latch when undriven, low byte from latch in mux
   assign addr = {mem_i.addr_hi_oe_n ? port_hi_i : mem_i.addr_hi,
      mem_i.addr_lo_oe_n ? lat : mem_i.addr_lo};

   always @(posedge clk_i) begin
      if (mem_i.ale) begin
         lat <= mem_i.ad;
      end
      if (!mem_i.wr_n && !mem_i.ad_oe_n) begin
         mem[addr] <= mem_i.ad;
      end
      if (!mem_i.rd_n) begin
         last <= mem[addr];
      end
   end

   // released lines show the inverse of the last byte
   assign ad_o = !mem_i.rd_n ? mem[addr] : ~last;
endmodule // emt_sram_model

// ### sim/emt_ctrl_tb_top.sv
// testbench: registers, timing sweep, bus forms, update during a move
module emt_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import emt_pkg::*;

   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   emt_wb_req_t wb_i = '0;
   logic wb_ack_o;
   logic [31:0] wb_dat_o;
   logic busy_o;
   logic [7:0] ad_i;
   emt_pins_t mem_o;
   int n_errors = 0;
   int compares = 0;
   int n_busy, n_stb, n_pre, n_post, n_ale, n_hi;
   logic [31:0] rd;

   always #25 clk_i = ~clk_i;

   emt_ctrl emt_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .wb_i(wb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
      .busy_o(busy_o), .ad_i(ad_i), .mem_o(mem_o));
   emt_sram_model emt_sram_model_inst (.clk_i(clk_i), .mem_i(mem_o),
      .port_hi_i(8'h3c), .ad_o(ad_i));

   // ----------------------------------------------------------------
   // pin monitor: phase lengths of the running move
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (busy_o === 1'b1) n_busy++;
      if (mem_o.ale === 1'b1) n_ale++;
      if (mem_o.addr_hi_oe_n === 1'b0) n_hi++;
      if (mem_o.rd_n === 1'b0 || mem_o.wr_n === 1'b0) n_stb++;
      else if (mem_o.addr_lo_oe_n === 1'b0) begin
         if (n_stb == 0) n_pre++;
         else n_post++;
      end
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic wb(input logic we, input logic [9:0] idx,
      input logic [3:0] sel, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: sel,
         dat: d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) chk("bus ack", 1, 0);
      rd = wb_dat_o;
      wb_i <= '0;
   endtask

   task automatic setup(input logic [2:0] code, input logic [7:0] t);
      wb(1'b1, IDX_TIMING, 4'h1, {24'h0, t});
      wb(1'b1, IDX_CFG, 4'h1, {27'h0, code, 2'b00});
   endtask

   task automatic start(input logic wr, input logic wide);
      n_busy = 0;
      n_stb = 0;
      n_pre = 0;
      n_post = 0;
      n_ale = 0;
      n_hi = 0;
      wb(1'b1, IDX_CMD, 4'h1, {29'h0, wide, wr, 1'b1});
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while ((busy_o !== 1'b0 || n_busy == 0) && n < 200);
      if (n >= 200) chk("idle wait", 1, 0);
   endtask

   task automatic move(input logic wr, input logic wide);
      start(wr, wide);
      wait_idle();
   endtask

   task automatic chk_counts(input logic [7:0] t, input logic mux);
      int s, w, h;
      s = t[7:6];
      w = t[5:2] + 1;
      h = t[1:0];
      chk("busy cycles", s + w + h + 4 + (mux ? 2 : 0), n_busy);
      chk("strobe cycles", w, n_stb);
      if (!mux) begin
         chk("setup cycles", s + 2, n_pre);
         chk("hold cycles", h, n_post);
      end
      wb(1'b0, IDX_CMD, 4'h1, 0);
      chk("done flag", 1, rd[ST_DONE]);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      wb(1'b0, IDX_TIMING, 4'hf, 0);
      chk("timing reset", {24'h0, RST_TIMING}, rd);
      wb(1'b1, IDX_TIMING, 4'hf, 32'h0000005a);
      wb(1'b0, IDX_TIMING, 4'hf, 0);
      chk("timing readback", 32'h0000005a, rd);
      wb(1'b1, 10'h000, 4'hf, 32'hffffffff);
      wb(1'b0, 10'h000, 4'hf, 0);
      chk("unmapped read", 0, rd);
   endtask

   task automatic t_sweep();
      logic [7:0] tt [4] = '{8'h00, 8'hff, 8'h6d, 8'h92};
      foreach (tt[i]) begin
         setup(3'h5, tt[i]);
         move(1'b1, 1'b1);
         chk_counts(tt[i], 1'b0);
      end
   endtask

   task automatic t_modes();
      logic [2:0] code;
      logic [15:0] a;
      logic [7:0] d;
      logic mux, wide, bank;
      wb(1'b1, IDX_PAGE, 4'h1, 32'h0000007e);
      for (int c = 1; c < 8; c++) begin
         for (int k = 0; k < 2; k++) begin
            if (c != 4) begin
               code = 3'(c);
               wide = k[0];
               mux = !code[2];
               bank = (code[1:0] == 2'h2);
               d = 8'(8'ha0 + 2 * c + k);
               a = {wide ? 8'h12 : (bank ? 8'h7e : 8'h3c), 8'(8'h40 + c)};
               setup(code, 8'h10);
               wb(1'b1, IDX_PTR, 4'h3, {16'h0, 8'h12, 8'(8'h40 + c)});
               wb(1'b1, IDX_WDATA, 4'h1, {24'h0, d});
               move(1'b1, wide);
               chk_counts(8'h10, mux);
               chk("stored byte", d, emt_sram_model_inst.mem[a]);
               chk("upper driven", wide || bank, n_hi != 0);
               chk("latch pulses", mux, n_ale);
               move(1'b0, wide);
               wb(1'b0, IDX_RDATA, 4'h1, 0);
               chk("read byte", d, rd[7:0]);
            end else begin
               setup(3'h4, 8'h10);
               start(1'b1, k[0]);
               repeat (4) @(posedge clk_i);
               chk("refused move", 0, n_busy);
            end
         end
      end
   endtask

   task automatic t_midmove();
      setup(3'h5, 8'hff);
      start(1'b1, 1'b1);
      wb(1'b1, IDX_TIMING, 4'h1, 32'h0);
      wb(1'b0, IDX_CMD, 4'h1, 0);
      chk("busy flag", 1, rd[ST_BUSY]);
      chk("done cleared", 0, rd[ST_DONE]);
      wait_idle();
      chk_counts(8'hff, 1'b0);
      move(1'b1, 1'b1);
      chk_counts(8'h00, 1'b0);
   endtask

   // ----------------------------------------------------------------
   // run control
   // ----------------------------------------------------------------
   task automatic print_verdict();
      if (n_errors == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_sweep();
      t_modes();
      t_midmove();
      print_verdict();
   end

   initial begin
      #2000000;
      n_errors++;
      print_verdict();
   end
endmodule // emt_ctrl_tb_top
